// file: inc/lpm_pkg.sv
// Shared constants and types for the low-power mode and reset controller.
package lpm_pkg;
  // Clock rate; the high-frequency clock fc is the block clock itself.
  localparam int CLK_HZ = 50_000_000;
  localparam int FC_HZ = CLK_HZ;
  // Least external reset hold, in fc periods, rounded up to cycles.
  localparam int EXT_LOW_FC = 12;
  localparam int EXT_LOW_CYC = (EXT_LOW_FC * CLK_HZ + FC_HZ - 1) / FC_HZ;
  // Host holds the pin a little longer to cover the two-stage sampler.
  localparam int EXT_DRIVE_CYC = EXT_LOW_CYC + 4;
  // Longest malfunction reset, in fc periods, rounded down to cycles.
  localparam int MAL_FC = 24;
  localparam int MAL_CYC = (MAL_FC * CLK_HZ) / FC_HZ;
  localparam int CNT_W = 6;
  // Warm-up time for the high-frequency oscillator, in microseconds.
  localparam int WARM_US = 4000;
  localparam int WARM_CYC = (WARM_US / 1000) * (CLK_HZ / 1000);
  // Field positions in system_control_two.
  localparam int HOSC_BIT = 7;
  localparam int LOSC_BIT = 6;
  localparam int SYSTEM_CLOCK_SELECT_BIT = 5;
  localparam int HALT_BIT = 2;
  localparam logic [7:0] SYS2_RESET = 8'h80;
  // Field positions in time_base_control.
  localparam int TBE_BIT = 7;
  localparam int TBCK_LSB = 0;
  localparam int TBCK_W = 3;
  localparam logic [7:0] TBC_RESET = 8'h00;
  // Time base prescaler and the tap of its lowest selectable source.
  localparam int TB_DIV_W = 16;
  localparam int TB_TAP_BASE = 8;
  // Reset vector location.
  localparam logic [15:0] RESET_VECTOR = 16'hFFFE;
  // Address areas from which an instruction fetch is trapped.
  localparam logic [15:0] SFR_LO = 16'h0000;
  localparam logic [15:0] SFR_HI = 16'h003F;
  localparam logic [15:0] RAM_LO = 16'h0040;
  localparam logic [15:0] RAM_HI = 16'h023F;
  localparam logic [15:0] DBR_LO = 16'h0F80;
  localparam logic [15:0] DBR_HI = 16'h0FFF;
  // Host command port offsets and bit positions.
  localparam logic [7:0] CMD_OFF = 8'h00;
  localparam logic [7:0] CFG_OFF = 8'h04;
  localparam logic [7:0] STAT_OFF = 8'h08;
  localparam int CMD_SLOW = 0;
  localparam int CMD_FAST = 1;
  localparam int CMD_HALT = 2;
  localparam int CMD_EXTRST = 3;
  localparam int CFG_IMF = 0;
  localparam int CFG_EF6 = 1;
  localparam int CFG_TRAP = 2;
  localparam int CFG_TBE = 3;
  localparam int CFG_TBCK = 4;
  // Operating modes.
  typedef enum logic [1:0] {
    RUN_FAST_SINGLE, RUN_FAST_DUAL, RUN_SLOW_OSC_ON, RUN_SLOW_OSC_OFF
  } opmode_t;
endpackage

// file: inc/lpm_if.sv
// Link between the system-control logic and the CPU and reset circuitry.
`timescale 1ns/1ns
interface lpm_if;
  logic sysWr;
  logic [7:0] sysWdata;
  logic [7:0] sysRdata;
  logic tbcWr;
  logic [7:0] tbcWdata;
  logic masterIntEn;
  logic tbIntEn;
  logic tbIrqClr;
  logic tbIrqLatch;
  logic tbIntService;
  logic resumeNext;
  logic cpuHold;
  logic wdtIrq;
  logic wdtRstReq;
  logic wdtEnable;
  logic fetchValid;
  logic [15:0] fetchAddr;
  logic trapRamSel;
  logic clocksSynced;
  logic coreReset;
  logic vectorLoad;
  logic [15:0] vectorAddr;
  logic rstDevOut;
  logic rstDevOeN;
  logic rstExtOut;
  logic rstExtOeN;
  logic rstLevel;
  // Pin has a pull-up; either party pulls it low.
  assign rstLevel = !((!rstDevOeN && !rstDevOut) ||
                      (!rstExtOeN && !rstExtOut));
  modport dev(
    input sysWr, sysWdata, tbcWr, tbcWdata, masterIntEn, tbIntEn, tbIrqClr,
    input wdtIrq, wdtRstReq, fetchValid, fetchAddr, trapRamSel, clocksSynced,
    input rstLevel,
    output sysRdata, tbIrqLatch, tbIntService, resumeNext, cpuHold,
    output wdtEnable, coreReset, vectorLoad, vectorAddr, rstDevOut, rstDevOeN
  );
  modport host(
    output sysWr, sysWdata, tbcWr, tbcWdata, masterIntEn, tbIntEn, tbIrqClr,
    output wdtIrq, wdtRstReq, fetchValid, fetchAddr, trapRamSel, clocksSynced,
    output rstExtOut, rstExtOeN,
    input sysRdata, tbIrqLatch, tbIntService, resumeNext, cpuHold,
    input wdtEnable, coreReset, vectorLoad, vectorAddr, rstLevel
  );
endinterface

// file: design/lpm_device.sv
// Deep halt modes, system clock switching and reset generation.
`timescale 1ns/1ns
module lpm_device (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Link to the core and reset circuitry.
  lpm_if.dev link,
  // Peripheral-side controls and status.
  output logic periphClkEn,
  output logic tbtClkEn,
  output lpm_pkg::opmode_t opMode
);

  logic pinS1_q;
  logic pinS2_q;
  logic [lpm_pkg::CNT_W-1:0] extCnt_q;
  logic extRst_q;
  logic [lpm_pkg::CNT_W-1:0] malCnt_q;
  logic inReset;
  logic malReq;
  logic trapHit;
  logic clkFault;
  logic [7:0] sys2_q;
  logic [7:0] tbc_q;
  logic sysckEff_q;
  logic wdtIrqD_q;
  logic haltAccept;
  logic haltEnd;
  logic wakeGate;
  logic [lpm_pkg::TB_DIV_W-1:0] prescale_q;
  logic tap;
  logic tapD_q;
  logic [lpm_pkg::TBCK_W-1:0] tbSel;

  // Two-stage sampler for the shared reset pin.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinS1_q <= 1'b1;
      pinS2_q <= 1'b1;
    end else begin
      pinS1_q <= link.rstLevel;
      pinS2_q <= pinS1_q;
    end
  end

  // External reset: qualified after the minimum low time, held to release.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      extCnt_q <= '0;
      extRst_q <= 1'b0;
    end else if (pinS2_q) begin
      extCnt_q <= '0;
      extRst_q <= 1'b0;
    end else if (extCnt_q == lpm_pkg::CNT_W'(lpm_pkg::EXT_LOW_CYC - 1)) begin
      extRst_q <= 1'b1;
    end else begin
      extCnt_q <= extCnt_q + 1'b1;
    end
  end

  // Trapped fetch areas; the RAM area only when software arms it.
  always_comb begin
    trapHit = link.fetchValid && !inReset &&
      ((link.fetchAddr >= lpm_pkg::SFR_LO &&
        link.fetchAddr <= lpm_pkg::SFR_HI) ||
       (link.fetchAddr >= lpm_pkg::DBR_LO &&
        link.fetchAddr <= lpm_pkg::DBR_HI) ||
       (link.trapRamSel && link.fetchAddr >= lpm_pkg::RAM_LO &&
        link.fetchAddr <= lpm_pkg::RAM_HI));
  end

  // Oscillator-enable writes that would leave the core without a clock.
  always_comb begin
    clkFault = 1'b0;
    if (link.sysWr && !inReset) begin
      clkFault =
        (sys2_q[lpm_pkg::HOSC_BIT] && sys2_q[lpm_pkg::LOSC_BIT] &&
         !link.sysWdata[lpm_pkg::HOSC_BIT] &&
         !link.sysWdata[lpm_pkg::LOSC_BIT]) ||
        (sys2_q[lpm_pkg::HOSC_BIT] && !link.sysWdata[lpm_pkg::HOSC_BIT] &&
         !sys2_q[lpm_pkg::SYSTEM_CLOCK_SELECT_BIT]) ||
        (sys2_q[lpm_pkg::LOSC_BIT] && !link.sysWdata[lpm_pkg::LOSC_BIT] &&
         sys2_q[lpm_pkg::SYSTEM_CLOCK_SELECT_BIT]);
    end
  end

  assign malReq = link.wdtRstReq || trapHit || clkFault;
  assign inReset = extRst_q || (malCnt_q != '0);

  // Malfunction reset timer. It comes out of power-up loaded, since this
  // logic is not cleared by power-on in silicon either.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      malCnt_q <= lpm_pkg::CNT_W'(lpm_pkg::MAL_CYC);
    end else if (malReq && malCnt_q == '0) begin
      malCnt_q <= lpm_pkg::CNT_W'(lpm_pkg::MAL_CYC);
    end else if (malCnt_q != '0) begin
      malCnt_q <= malCnt_q - 1'b1;
    end
  end

  // Reset outputs: pin drive during malfunction reset, vector on release.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link.rstDevOut <= 1'b0;
      link.rstDevOeN <= 1'b1;
      link.coreReset <= 1'b1;
      link.vectorLoad <= 1'b0;
      link.vectorAddr <= lpm_pkg::RESET_VECTOR;
    end else begin
      link.rstDevOut <= 1'b0;
      link.rstDevOeN <= !(malReq || malCnt_q > 1);
      // A malfunction request holds the core at the very next edge.
      link.coreReset <= inReset || malReq;
      link.vectorLoad <= link.coreReset && !inReset;
      link.vectorAddr <= lpm_pkg::RESET_VECTOR;
    end
  end

  // A watchdog interrupt in this or the previous cycle vetoes halt entry.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdtIrqD_q <= 1'b0;
    end else begin
      wdtIrqD_q <= link.wdtIrq;
    end
  end

  assign haltAccept = link.sysWr && !clkFault && !inReset &&
    link.sysWdata[lpm_pkg::HALT_BIT] && !sys2_q[lpm_pkg::HALT_BIT] &&
    !link.wdtIrq && !wdtIrqD_q;

  // Free-running prescaler; it is not restarted on entry, so the first
  // falling edge of the chosen tap can come early.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prescale_q <= '0;
      tapD_q <= 1'b0;
    end else begin
      prescale_q <= prescale_q + 1'b1;
      tapD_q <= tap;
    end
  end

  assign tbSel = tbc_q[lpm_pkg::TBCK_LSB +: lpm_pkg::TBCK_W];
  assign tap = prescale_q[lpm_pkg::TB_TAP_BASE + int'(tbSel)];
  assign haltEnd = sys2_q[lpm_pkg::HALT_BIT] && tapD_q && !tap;
  assign wakeGate = link.masterIntEn && link.tbIntEn &&
    tbc_q[lpm_pkg::TBE_BIT];

  // System control register, including the self-clearing halt bit.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sys2_q <= lpm_pkg::SYS2_RESET;
    end else if (inReset) begin
      sys2_q <= lpm_pkg::SYS2_RESET;
    end else if (link.sysWr && !clkFault) begin
      sys2_q <= link.sysWdata;
      sys2_q[lpm_pkg::HALT_BIT] <= haltAccept;
    end else if (haltEnd) begin
      sys2_q[lpm_pkg::HALT_BIT] <= 1'b0;
    end
  end

  // Time base control register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tbc_q <= lpm_pkg::TBC_RESET;
    end else if (inReset) begin
      tbc_q <= lpm_pkg::TBC_RESET;
    end else if (link.tbcWr) begin
      tbc_q <= link.tbcWdata;
    end
  end

  // Effective clock select: to slow at once, back to fast only in sync.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sysckEff_q <= 1'b0;
    end else if (inReset) begin
      sysckEff_q <= 1'b0;
    end else if (sys2_q[lpm_pkg::SYSTEM_CLOCK_SELECT_BIT]) begin
      sysckEff_q <= 1'b1;
    end else if (link.clocksSynced) begin
      sysckEff_q <= 1'b0;
    end
  end

  // Time base interrupt latch; a new setting wins over a clear.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link.tbIrqLatch <= 1'b0;
    end else if (inReset) begin
      link.tbIrqLatch <= 1'b0;
    end else if (haltAccept && tbc_q[lpm_pkg::TBE_BIT]) begin
      link.tbIrqLatch <= 1'b1;
    end else if (link.tbIrqClr) begin
      link.tbIrqLatch <= 1'b0;
    end
  end

  // Release actions and the core hold during the halt.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link.tbIntService <= 1'b0;
      link.resumeNext <= 1'b0;
      link.cpuHold <= 1'b0;
    end else begin
      link.tbIntService <= haltEnd && wakeGate;
      link.resumeNext <= haltEnd && !wakeGate;
      // The core freezes its state with the PC two past the entry.
      link.cpuHold <= sys2_q[lpm_pkg::HALT_BIT] && !haltEnd
        && !inReset;
    end
  end

  // Register readback, watchdog enable and peripheral clock gating.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link.sysRdata <= lpm_pkg::SYS2_RESET;
      link.wdtEnable <= 1'b1;
      periphClkEn <= 1'b1;
      tbtClkEn <= 1'b1;
    end else begin
      link.sysRdata <= sys2_q;
      link.wdtEnable <= 1'b1;
      periphClkEn <= !(sys2_q[lpm_pkg::HALT_BIT] && !haltEnd);
      tbtClkEn <= 1'b1;
    end
  end

  // Operating mode from the oscillator enables and clock select.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      opMode <= lpm_pkg::RUN_FAST_SINGLE;
    end else if (inReset) begin
      opMode <= lpm_pkg::RUN_FAST_SINGLE;
    end else if (sysckEff_q) begin
      opMode <= sys2_q[lpm_pkg::HOSC_BIT] ? lpm_pkg::RUN_SLOW_OSC_ON :
        lpm_pkg::RUN_SLOW_OSC_OFF;
    end else begin
      opMode <= sys2_q[lpm_pkg::LOSC_BIT] ? lpm_pkg::RUN_FAST_DUAL :
        lpm_pkg::RUN_FAST_SINGLE;
    end
  end

endmodule

// file: design/lpm_host.sv
// Core-side sequencer: mode changes, halt entry and external reset.
`timescale 1ns/1ns
module lpm_host #(
  parameter int WARM_CYCLES = lpm_pkg::WARM_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Link to the system-control logic.
  lpm_if.host link,
  // Command port.
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  // Core events.
  input wire logic wdtIrqIn,
  input wire logic wdtRstIn,
  input wire logic fetchValidIn,
  input wire logic [15:0] fetchAddrIn,
  input wire logic syncedIn,
  input wire logic tbIrqClrIn,
  // Peripheral shutdown before a halt.
  output logic periphOff
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_SLOW_SEL, ST_SLOW_XOFF, ST_FAST_XON, ST_FAST_WARM,
    ST_FAST_SEL, ST_HALT_QUIET, ST_HALT_SET, ST_EXT_RST
  } hstate_t;

  hstate_t state_q;
  logic [17:0] cnt_q;
  logic [7:0] cfg_q;
  logic cmdWr;

  assign cmdWr = regWr && regAddr == lpm_pkg::CMD_OFF &&
    state_q == ST_IDLE;

  // Sequencer for the documented software orderings.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      link.sysWr <= 1'b0;
      link.sysWdata <= lpm_pkg::SYS2_RESET;
      periphOff <= 1'b0;
      link.rstExtOut <= 1'b0;
      link.rstExtOeN <= 1'b1;
    end else begin
      link.sysWr <= 1'b0;
      link.sysWdata <= link.sysRdata;
      unique case (state_q)
        ST_IDLE: begin
          periphOff <= 1'b0;
          if (cmdWr && regWdata[lpm_pkg::CMD_EXTRST]) begin
            state_q <= ST_EXT_RST;
            cnt_q <= '0;
          end else if (cmdWr && regWdata[lpm_pkg::CMD_SLOW]) begin
            state_q <= ST_SLOW_SEL;
          end else if (cmdWr && regWdata[lpm_pkg::CMD_FAST]) begin
            state_q <= ST_FAST_XON;
          end else if (cmdWr && regWdata[lpm_pkg::CMD_HALT]) begin
            state_q <= ST_HALT_QUIET;
          end
        end
        ST_SLOW_SEL: begin
          link.sysWr <= 1'b1;
          link.sysWdata[lpm_pkg::SYSTEM_CLOCK_SELECT_BIT] <= 1'b1;
          state_q <= ST_SLOW_XOFF;
        end
        ST_SLOW_XOFF: begin
          if (link.sysRdata[lpm_pkg::SYSTEM_CLOCK_SELECT_BIT]) begin
            link.sysWr <= 1'b1;
            link.sysWdata[lpm_pkg::HOSC_BIT] <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
        ST_FAST_XON: begin
          link.sysWr <= 1'b1;
          link.sysWdata[lpm_pkg::HOSC_BIT] <= 1'b1;
          cnt_q <= '0;
          state_q <= ST_FAST_WARM;
        end
        ST_FAST_WARM: begin
          // Stands in for the timer pair counting the warm-up.
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == 18'(WARM_CYCLES - 1)) begin
            state_q <= ST_FAST_SEL;
          end
        end
        ST_FAST_SEL: begin
          link.sysWr <= 1'b1;
          link.sysWdata[lpm_pkg::SYSTEM_CLOCK_SELECT_BIT] <= 1'b0;
          state_q <= ST_IDLE;
        end
        ST_HALT_QUIET: begin
          periphOff <= 1'b1;
          state_q <= ST_HALT_SET;
        end
        ST_HALT_SET: begin
          link.sysWr <= 1'b1;
          link.sysWdata[lpm_pkg::HALT_BIT] <= 1'b1;
          state_q <= ST_IDLE;
        end
        ST_EXT_RST: begin
          link.rstExtOeN <= 1'b0;
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == 18'(lpm_pkg::EXT_DRIVE_CYC - 1)) begin
            link.rstExtOeN <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Configuration register; a write also loads time_base_control.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= 8'h00;
      link.tbcWr <= 1'b0;
      link.tbcWdata <= lpm_pkg::TBC_RESET;
    end else begin
      link.tbcWr <= 1'b0;
      if (regWr && regAddr == lpm_pkg::CFG_OFF) begin
        cfg_q <= regWdata;
        link.tbcWr <= 1'b1;
        link.tbcWdata <= {regWdata[lpm_pkg::CFG_TBE], 4'h0,
          regWdata[lpm_pkg::CFG_TBCK +: lpm_pkg::TBCK_W]};
      end
    end
  end

  // Core event outputs, registered on the way out.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link.wdtIrq <= 1'b0;
      link.wdtRstReq <= 1'b0;
      link.fetchValid <= 1'b0;
      link.fetchAddr <= 16'h0000;
      link.clocksSynced <= 1'b0;
      link.tbIrqClr <= 1'b0;
    end else begin
      link.wdtIrq <= wdtIrqIn;
      link.wdtRstReq <= wdtRstIn;
      link.fetchValid <= fetchValidIn;
      link.fetchAddr <= fetchAddrIn;
      link.clocksSynced <= syncedIn;
      link.tbIrqClr <= tbIrqClrIn;
    end
  end

  assign link.masterIntEn = cfg_q[lpm_pkg::CFG_IMF];
  assign link.tbIntEn = cfg_q[lpm_pkg::CFG_EF6];
  assign link.trapRamSel = cfg_q[lpm_pkg::CFG_TRAP];

  // Read port: data stands in the cycle after the strobe.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= 8'h00;
    end else if (regRd && regAddr == lpm_pkg::CFG_OFF) begin
      regRdata <= cfg_q;
    end else if (regRd && regAddr == lpm_pkg::STAT_OFF) begin
      regRdata <= {state_q != ST_IDLE, link.tbIrqLatch, link.coreReset,
        link.cpuHold, link.wdtEnable, link.sysRdata[lpm_pkg::SYSTEM_CLOCK_SELECT_BIT],
        link.sysRdata[lpm_pkg::HOSC_BIT], link.rstLevel};
    end else begin
      regRdata <= 8'h00;
    end
  end

endmodule

// file: verification/lpm_chk.sv
// Concurrent checks on the link between the two ends of the controller.
`timescale 1ns/1ns
module lpm_chk (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Register link.
  input wire logic sysWr,
  input wire logic [7:0] sysWdata,
  input wire logic tbcWr,
  input wire logic [7:0] tbcWdata,
  // Halt and time base interrupt.
  input wire logic masterIntEn,
  input wire logic tbIntEn,
  input wire logic tbIrqLatch,
  input wire logic tbIntService,
  input wire logic resumeNext,
  input wire logic cpuHold,
  input wire logic wdtIrq,
  // Reset sources, vector and pin.
  input wire logic wdtRstReq,
  input wire logic fetchValid,
  input wire logic [15:0] fetchAddr,
  input wire logic trapRamSel,
  input wire logic coreReset,
  input wire logic vectorLoad,
  input wire logic [15:0] vectorAddr,
  input wire logic rstDevOut,
  input wire logic rstDevOeN,
  input wire logic rstLevel
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic tbe_q;
  logic [5:0] devLow_q;
  logic [5:0] pinLow_q;
  logic halt;
  logic trap;
  // Enable shadow and low-pin runs; the runs saturate so they never wrap.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tbe_q <= 1'h0;
      devLow_q <= 6'h00;
      pinLow_q <= 6'h00;
    end else begin
      tbe_q <= coreReset ? 1'h0 : (tbcWr ? tbcWdata[7] : tbe_q);
      devLow_q <= rstDevOeN ? 6'h00 : devLow_q + 6'(devLow_q != 6'h3F);
      pinLow_q <= rstLevel ? 6'h00 : pinLow_q + 6'(pinLow_q != 6'h3F);
    end
  end
  // Halt requests and trapped fetches outside reset.
  assign halt = sysWr && sysWdata[2] && !coreReset && !cpuHold;
  assign trap = fetchValid && !coreReset && (fetchAddr <= lpm_pkg::SFR_HI
    || (fetchAddr >= lpm_pkg::DBR_LO && fetchAddr <= lpm_pkg::DBR_HI)
    || (trapRamSel && fetchAddr >= lpm_pkg::RAM_LO
    && fetchAddr <= lpm_pkg::RAM_HI));
  property p_pin0; !rstDevOeN |-> !rstDevOut && coreReset; endproperty
  a_pin0: assert property (p_pin0) else $error("Pin drive wrong.");
  property p_mal; devLow_q <= 6'h18; endproperty
  a_mal: assert property (p_mal) else $error("Pulse long.");
  property p_vec;
    vectorLoad |-> vectorAddr == lpm_pkg::RESET_VECTOR ##1 !vectorLoad;
  endproperty
  a_vec: assert property (p_vec) else $error("Vector wrong.");
  property p_enter; halt && !wdtIrq && !$past(wdtIrq) |-> ##2 cpuHold;
  endproperty
  a_enter: assert property (p_enter) else $error("No halt.");
  property p_block; halt && (wdtIrq || $past(wdtIrq)) |-> ##2 !cpuHold;
  endproperty
  a_block: assert property (p_block) else $error("Halt taken.");
  property p_latch; halt && !wdtIrq && !$past(wdtIrq) && tbe_q |=> tbIrqLatch;
  endproperty
  a_latch: assert property (p_latch) else $error("Latch unset.");
  property p_rel;
    $fell(cpuHold) && !coreReset |-> ##[0:1] resumeNext != tbIntService
      && tbIntService == (masterIntEn && tbIntEn && tbe_q);
  endproperty
  a_rel: assert property (p_rel) else $error("Bad release.");
  property p_trap; trap |=> coreReset; endproperty
  a_trap: assert property (p_trap) else $error("No trap reset.");
  property p_wdt; wdtRstReq && !coreReset |=> coreReset; endproperty
  a_wdt: assert property (p_wdt) else $error("No wdt reset.");
  property p_ext; pinLow_q == 6'h0D |-> ##[0:3] coreReset; endproperty
  a_ext: assert property (p_ext) else $error("No pin reset.");
  cover property ($fell(cpuHold) ##[0:1] tbIntService);
  cover property ($fell(cpuHold) ##[0:1] resumeNext);
  cover property (trap ##1 coreReset);
endmodule

// file: verification/tb.sv
// Self-checking bench: both ends joined by the link, driven by commands.
`timescale 1ns/1ns
module tb;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'h0;
  logic regRd = 1'h0;
  logic [7:0] regRdata;
  logic wdtIrqIn = 1'h0;
  logic wdtRstIn = 1'h0;
  logic fetchValidIn = 1'h0;
  logic [15:0] fetchAddrIn = 16'h0000;
  logic syncedIn = 1'h0;
  logic tbIrqClrIn = 1'h0;
  logic periphClkEn;
  logic tbtClkEn;
  logic periphOff;
  lpm_pkg::opmode_t opMode;
  logic [7:0] st;
  int n_errors = 0;
  int checks_done = 0;
  int resumes = 0;
  int services = 0;
  int holdCyc = 0;
  int offCyc = 0;
  // Fetch addresses at area edges and one inside RAM; case is {trap RAM, reset expected}.
  logic [15:0] tAddr [6] = '{16'h0F80, 16'h1000, 16'h0100, 16'h023F,
    16'h003F, 16'h0240};
  logic [1:0] tCase [6] = '{2'h1, 2'h0, 2'h0, 2'h3, 2'h1, 2'h2};
  lpm_if link();
  lpm_device u_lpm_device (.clk(clk), .rst_n(rst_n), .link(link),
    .periphClkEn(periphClkEn), .tbtClkEn(tbtClkEn), .opMode(opMode));
  // A short warm-up keeps the fast switch quick in simulation.
  lpm_host #(.WARM_CYCLES(20)) u_lpm_host (.clk(clk), .rst_n(rst_n),
    .link(link), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .wdtIrqIn(wdtIrqIn),
    .wdtRstIn(wdtRstIn), .fetchValidIn(fetchValidIn),
    .fetchAddrIn(fetchAddrIn), .syncedIn(syncedIn),
    .tbIrqClrIn(tbIrqClrIn), .periphOff(periphOff));
  lpm_chk u_lpm_chk (.clk(clk), .rst_n(rst_n), .sysWr(link.sysWr),
    .sysWdata(link.sysWdata), .tbcWr(link.tbcWr), .tbcWdata(link.tbcWdata),
    .masterIntEn(link.masterIntEn), .tbIntEn(link.tbIntEn),
    .tbIrqLatch(link.tbIrqLatch), .tbIntService(link.tbIntService),
    .resumeNext(link.resumeNext), .cpuHold(link.cpuHold),
    .wdtIrq(link.wdtIrq), .wdtRstReq(link.wdtRstReq),
    .fetchValid(link.fetchValid), .fetchAddr(link.fetchAddr),
    .trapRamSel(link.trapRamSel), .coreReset(link.coreReset),
    .vectorLoad(link.vectorLoad), .vectorAddr(link.vectorAddr),
    .rstDevOut(link.rstDevOut), .rstDevOeN(link.rstDevOeN),
    .rstLevel(link.rstLevel));
  // Clock of 20 ns period.
  always #10 clk = ~clk;
  // Tally release pulses and halted cycles for the halt scenarios.
  always @(posedge clk) begin
    if (link.resumeNext === 1'h1) resumes++;
    if (link.tbIntService === 1'h1) services++;
    if (link.cpuHold === 1'h1) holdCyc++;
    if (periphOff === 1'h1) offCyc++;
  end
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d.", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // One-cycle strobes on the command port, launched after an edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'h1;
    @(posedge clk);
    regWr <= 1'h0;
  endtask
  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge clk);
    regRd <= 1'h0;
    #1 st = regRdata;
  endtask
  task automatic idle();
    for (int i = 0; i < 100; i++) begin
      rd(lpm_pkg::STAT_OFF);
      if (st[7] === 1'h0) break;
    end
    chk(16'(st[7]), 16'h0000);
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return link.cpuHold;
      1: return link.vectorLoad;
      default: return link.coreReset;
    endcase
  endfunction
  // Bounded wait for a link signal; a pulse is seen since we look at #1.
  task automatic wt(input int s, input logic v);
    for (int i = 0; i < 2000 && sig(s) !== v; i++) begin
      @(posedge clk);
      #1;
    end
    chk(16'(sig(s)), 16'(v));
  endtask
  // Clear the latch, halt, and check the freeze and the release kind.
  task automatic halt(input logic [7:0] cfg, input logic gate);
    wr(lpm_pkg::CFG_OFF, cfg);
    tbIrqClrIn <= 1'h1;
    @(posedge clk);
    tbIrqClrIn <= 1'h0;
    repeat (3) @(posedge clk);
    resumes = 0;
    services = 0;
    offCyc = 0;
    wr(lpm_pkg::CMD_OFF, 8'h04);
    wt(0, 1'h1);
    chk(16'(offCyc), 16'h0002);
    chk(16'({periphClkEn, tbtClkEn}), 16'h0001);
    chk(16'(link.tbIrqLatch), 16'(cfg[3]));
    wt(0, 1'h0);
    repeat (2) @(posedge clk);
    #1 chk({services[7:0], resumes[7:0]}, gate ? 16'h0100 : 16'h0001);
    chk(16'(periphClkEn), 16'h0001);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge clk);
    #1 chk(16'(link.rstLevel), 16'h0000);
    wt(1, 1'h1);
    chk(16'(opMode), 16'(lpm_pkg::RUN_FAST_SINGLE));
    rd(lpm_pkg::STAT_OFF);
    chk(16'(st), 16'h000B);
    rd(8'h10);
    chk(16'(st), 16'h0000);
    halt(8'h08, 1'h0);
    halt(8'h1B, 1'h1);
    halt(8'h03, 1'h0);
    // A watchdog interrupt around the halt write keeps the core running.
    wr(lpm_pkg::CFG_OFF, 8'h08);
    wdtIrqIn <= 1'h1;
    holdCyc = 0;
    wr(lpm_pkg::CMD_OFF, 8'h04);
    repeat (6) @(posedge clk);
    wdtIrqIn <= 1'h0;
    repeat (4) @(posedge clk);
    chk(16'(holdCyc), 16'h0000);
    wr(lpm_pkg::CMD_OFF, 8'h01);
    idle();
    chk(16'(opMode), 16'(lpm_pkg::RUN_SLOW_OSC_OFF));
    // The register copy trails the last write, so read status once more.
    rd(lpm_pkg::STAT_OFF);
    chk(16'(st[2:1]), 16'h0002);
    halt(8'h08, 1'h0);
    chk(16'(opMode), 16'(lpm_pkg::RUN_SLOW_OSC_OFF));
    // Without synchronism the core must stay on the slow clock.
    wr(lpm_pkg::CMD_OFF, 8'h02);
    idle();
    chk(16'(st[1]), 16'h0001);
    chk(16'(opMode), 16'(lpm_pkg::RUN_SLOW_OSC_ON));
    syncedIn <= 1'h1;
    repeat (4) @(posedge clk);
    chk(16'(opMode[1]), 16'h0000);
    wr(lpm_pkg::CMD_OFF, 8'h01);
    idle();
    wdtRstIn <= 1'h1;
    @(posedge clk);
    wdtRstIn <= 1'h0;
    wt(2, 1'h1);
    @(posedge clk);
    #1 chk(16'(link.rstLevel), 16'h0000);
    wt(1, 1'h1);
    chk(link.vectorAddr, 16'hFFFE);
    chk(16'(opMode), 16'(lpm_pkg::RUN_FAST_SINGLE));
    for (int k = 0; k < 6; k++) begin
      wr(lpm_pkg::CFG_OFF, {5'h00, tCase[k][1], 2'h0});
      fetchValidIn <= 1'h1;
      fetchAddrIn <= tAddr[k];
      @(posedge clk);
      fetchValidIn <= 1'h0;
      repeat (3) @(posedge clk);
      #1 chk(16'(link.coreReset), 16'(tCase[k][0]));
      if (tCase[k][0]) wt(1, 1'h1);
    end
    wr(lpm_pkg::CMD_OFF, 8'h08);
    wt(2, 1'h1);
    wt(1, 1'h1);
    conclude();
  end
  // A hang is cut short well after the sequence should have ended.
  initial begin
    #(20 * 60000);
    n_errors++;
    conclude();
  end
endmodule
